// *** shared/spcfg_pkg.sv ***
// package: constants, types and helpers of the serial port config select
package spcfg_pkg;

  // clock and timing
  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned SETTLE_NS = 10_000;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

  // switch field layout
  localparam int unsigned SW_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned RATE_W = 2;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned RATE_LSB = 6;

  // bit-rate setting codes
  localparam logic [1:0] RATE_NV = 2'h0;
  localparam logic [1:0] RATE_9K6 = 2'h1;
  localparam logic [1:0] RATE_38K4 = 2'h2;
  localparam logic [1:0] RATE_115K2 = 2'h3;

  // line rates in bits per second and clock divisors
  localparam int unsigned BAUD_9K6 = 9_600;
  localparam int unsigned BAUD_38K4 = 38_400;
  localparam int unsigned BAUD_115K2 = 115_200;
  localparam int unsigned DIV_W = 16;
  localparam logic [15:0] DIV_9K6 = 16'(MCLK_HZ / BAUD_9K6);
  localparam logic [15:0] DIV_38K4 = 16'(MCLK_HZ / BAUD_38K4);
  localparam logic [15:0] DIV_115K2 = 16'(MCLK_HZ / BAUD_115K2);

  // apb register map, byte addresses
  localparam int unsigned PADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_NV_ADDR = 12'h004;
  localparam logic [11:0] OFS_NV_RATE = 12'h008;
  localparam logic [11:0] OFS_RS232_DIV = 12'h00c;
  localparam logic [11:0] OFS_EFFECT = 12'h010;

  // status register fields
  localparam int unsigned ST_MODE_BIT = 0;
  localparam int unsigned ST_READY_BIT = 1;
  localparam int unsigned ST_ADDRNV_BIT = 2;
  localparam int unsigned ST_RATENV_BIT = 3;
  localparam int unsigned ST_SWADDR_LSB = 8;
  localparam int unsigned ST_SWRATE_LSB = 16;

  // effective register fields
  localparam int unsigned EF_ADDR_LSB = 0;
  localparam int unsigned EF_RATE_LSB = 8;
  localparam int unsigned EF_DIV_LSB = 16;

  // reset values
  localparam logic [5:0] NV_ADDR_RST = 6'h00;
  localparam logic [1:0] NV_RATE_RST = 2'h1;
  localparam logic [15:0] RS232_DIV_RST = DIV_9K6;

  // effective port configuration
  typedef struct packed {
    logic mode485;
    logic [5:0] nodeAddr;
    logic [1:0] rateCode;
    logic [15:0] baudDiv;
  } spcfg_cfg_t;

  // capture sequencer
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } spcfg_state_t;

  // divisor of a bit-rate code; a zero code falls back to the slowest rate
  function automatic logic [15:0] spcfg_rate_div(input logic [1:0] code);
    logic [15:0] div;
    div = DIV_9K6;
    case (code)
      RATE_38K4: div = DIV_38K4;
      RATE_115K2: div = DIV_115K2;
      default: div = DIV_9K6;
    endcase
    return div;
  endfunction

endpackage

// *** rtl/spcfg_sync.sv ***
// two-flop synchroniser for pin inputs
module spcfg_sync #(
  parameter int unsigned W = 1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// *** rtl/spcfg_pick.sv ***
// picks a switch field or its stored fallback when the field is zero
module spcfg_pick #(
  parameter int unsigned W = 6
) (
  input wire logic [W-1:0] swField,
  input wire logic [W-1:0] nvField,
  output logic [W-1:0] value,
  output logic fromNv
);

  // zero on the switches selects the stored value
  assign fromNv = (swField == '0);
  assign value = fromNv ? nvField : swField;

endmodule

// *** rtl/spcfg_top.sv ***
// serial port config select: mode, node address and bit rate
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module spcfg_top
  import spcfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic selectPin,
  input wire logic [7:0] switchPins,
  input wire logic serialRxLine,
  input wire logic serialRxPos,
  input wire logic txData,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output spcfg_cfg_t portCfg,
  output logic cfgValid,
  output logic serialTxLine,
  output logic serialTxPos,
  output logic rxData
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

  // refuse settings the logic cannot serve
  generate
    if (SETTLE_CYCLES < 3) begin : g_bad_settle
      $error("SETTLE_CYCLES must cover the synchroniser latency");
    end
    if (ADDR_W + RATE_W != SW_W) begin : g_bad_fields
      $error("address and rate fields must fill the switch bank");
    end
  endgenerate

  // synchronised pins
  logic selSync;
  logic [7:0] swSync;
  logic rxNegSync;
  logic rxPosSync;

  // capture sequencer and held switch samples
  spcfg_state_t state_q;
  spcfg_state_t state_d;
  logic [CNT_W-1:0] settleCnt_q;
  logic [CNT_W-1:0] settleCnt_d;
  logic mode485_q;
  logic [5:0] swAddr_q;
  logic [1:0] swRate_q;

  // software registers
  logic [5:0] nvAddr_q;
  logic [5:0] nvAddr_d;
  logic [1:0] nvRate_q;
  logic [1:0] nvRate_d;
  logic [15:0] rs232Div_q;
  logic [15:0] rs232Div_d;

  // bus answer registers
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // output registers
  spcfg_cfg_t cfg_q;
  spcfg_cfg_t cfg_d;
  logic cfgValid_q;
  logic txLine_q;
  logic txLine_d;
  logic txPos_q;
  logic txPos_d;
  logic rxData_q;
  logic rxData_d;

  // select, switch and receive pins cross two flip-flops before use
  spcfg_sync #(
    .W(SW_W + 3)
  ) u_pin_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({selectPin, switchPins, serialRxLine, serialRxPos}),
    .dout({selSync, swSync, rxNegSync, rxPosSync})
  );

  // switch fields, switch 1 and switch 7 as the low bits
  logic [5:0] swAddrField;
  logic [1:0] swRateField;
  assign swAddrField = swSync[ADDR_LSB +: ADDR_W];
  assign swRateField = swSync[RATE_LSB +: RATE_W];

  // settle count then a single capture
  logic captureNow;
  assign captureNow = (state_q == ST_SETTLE) && (settleCnt_q == CNT_LAST);

  always_comb begin
    state_d = state_q;
    settleCnt_d = settleCnt_q;
    case (state_q)
      ST_SETTLE: begin
        settleCnt_d = settleCnt_q + 1'b1;
        if (captureNow) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        settleCnt_d = settleCnt_q;
      end
      default: begin
        state_d = ST_SETTLE;
        settleCnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_SETTLE;
      settleCnt_q <= '0;
    end else begin
      state_q <= state_d;
      settleCnt_q <= settleCnt_d;
    end
  end

  // held samples: taken once, kept until the next reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode485_q <= 1'b0;
      swAddr_q <= '0;
      swRate_q <= '0;
    end else if (captureNow) begin
      mode485_q <= ~selSync;
      swAddr_q <= swAddrField;
      swRate_q <= swRateField;
    end
  end

  // zero fields fall back to stored values, each on its own
  logic [5:0] pickAddr;
  logic [1:0] pickRate;
  logic addrFromNv;
  logic rateFromNv;

  spcfg_pick #(
    .W(ADDR_W)
  ) u_pick_addr (
    .swField(swAddr_q),
    .nvField(nvAddr_q),
    .value(pickAddr),
    .fromNv(addrFromNv)
  );

  spcfg_pick #(
    .W(RATE_W)
  ) u_pick_rate (
    .swField(swRate_q),
    .nvField(nvRate_q),
    .value(pickRate),
    .fromNv(rateFromNv)
  );

  // effective configuration; RS-232 ignores the switch fields
  logic isReady;
  logic [15:0] rs485Div;
  assign isReady = (state_q == ST_RUN);
  assign rs485Div = spcfg_rate_div(pickRate);

  always_comb begin
    cfg_d = cfg_q;
    if (isReady) begin
      cfg_d.mode485 = mode485_q;
      cfg_d.nodeAddr = mode485_q ? pickAddr : '0;
      cfg_d.rateCode = mode485_q ? pickRate : RATE_NV;
      cfg_d.baudDiv = mode485_q ? rs485Div : rs232Div_q;
    end
  end

  // line steering: RS-485 sends on the inverted leg plus the true leg and receives on the true leg only
  assign txLine_d = !isReady ? 1'b1 : (mode485_q ? ~txData : txData);
  assign txPos_d = (isReady && mode485_q) ? txData : 1'b0;
  assign rxData_d = !isReady ? 1'b1 : (mode485_q ? rxPosSync : rxNegSync);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_q <= '0;
      cfgValid_q <= 1'b0;
      txLine_q <= 1'b1;
      txPos_q <= 1'b0;
      rxData_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      cfgValid_q <= isReady;
      txLine_q <= txLine_d;
      txPos_q <= txPos_d;
      rxData_q <= rxData_d;
    end
  end

  // apb decode
  logic setupPhase;
  logic accessDone;
  logic hitStatus;
  logic hitNvAddr;
  logic hitNvRate;
  logic hitDiv;
  logic hitEffect;
  logic hitAny;
  logic [31:0] byteMask;
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready_q;
  assign hitStatus = (paddr == OFS_STATUS);
  assign hitNvAddr = (paddr == OFS_NV_ADDR);
  assign hitNvRate = (paddr == OFS_NV_RATE);
  assign hitDiv = (paddr == OFS_RS232_DIV);
  assign hitEffect = (paddr == OFS_EFFECT);
  assign hitAny = hitStatus | hitNvAddr | hitNvRate | hitDiv | hitEffect;
  assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                     {8{pstrb[1]}}, {8{pstrb[0]}}};

  // read views
  logic [31:0] statusWord;
  logic [31:0] effectWord;
  logic [31:0] readWord;
  always_comb begin
    statusWord = '0;
    statusWord[ST_MODE_BIT] = mode485_q;
    statusWord[ST_READY_BIT] = isReady;
    statusWord[ST_ADDRNV_BIT] = addrFromNv;
    statusWord[ST_RATENV_BIT] = rateFromNv;
    statusWord[ST_SWADDR_LSB +: ADDR_W] = swAddr_q;
    statusWord[ST_SWRATE_LSB +: RATE_W] = swRate_q;
    effectWord = '0;
    effectWord[EF_ADDR_LSB +: ADDR_W] = cfg_q.nodeAddr;
    effectWord[EF_RATE_LSB +: RATE_W] = cfg_q.rateCode;
    effectWord[EF_DIV_LSB +: DIV_W] = cfg_q.baudDiv;
  end

  assign readWord = hitStatus ? statusWord :
                    hitNvAddr ? {26'h0000000, nvAddr_q} :
                    hitNvRate ? {30'h00000000, nvRate_q} :
                    hitDiv ? {16'h0000, rs232Div_q} :
                    hitEffect ? effectWord : 32'h00000000;

  // answer prepared in setup, shown through the access phase
  always_comb begin
    prdata_d = prdata_q;
    pready_d = pready_q;
    pslverr_d = pslverr_q;
    if (setupPhase) begin
      prdata_d = pwrite ? 32'h00000000 : readWord;
      pready_d = 1'b1;
      pslverr_d = ~hitAny;
    end else if (accessDone) begin
      prdata_d = 32'h00000000;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
    end
  end

  // writes land only at the completing edge, per byte lane
  logic doWrite;
  logic [31:0] mergedAddr;
  logic [31:0] mergedRate;
  logic [31:0] mergedDiv;
  assign doWrite = accessDone && pwrite;
  assign mergedAddr = (pwdata & byteMask) |
                      ({26'h0000000, nvAddr_q} & ~byteMask);
  assign mergedRate = (pwdata & byteMask) |
                      ({30'h00000000, nvRate_q} & ~byteMask);
  assign mergedDiv = (pwdata & byteMask) |
                     ({16'h0000, rs232Div_q} & ~byteMask);
  assign nvAddr_d = (doWrite && hitNvAddr) ? mergedAddr[5:0] : nvAddr_q;
  assign nvRate_d = (doWrite && hitNvRate) ? mergedRate[1:0] : nvRate_q;
  assign rs232Div_d = (doWrite && hitDiv) ? mergedDiv[15:0] : rs232Div_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // stored fallback values and RS-232 divisor
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      nvAddr_q <= NV_ADDR_RST;
      nvRate_q <= NV_RATE_RST;
      rs232Div_q <= RS232_DIV_RST;
    end else begin
      nvAddr_q <= nvAddr_d;
      nvRate_q <= nvRate_d;
      rs232Div_q <= rs232Div_d;
    end
  end

  // ports straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign portCfg = cfg_q;
  assign cfgValid = cfgValid_q;
  assign serialTxLine = txLine_q;
  assign serialTxPos = txPos_q;
  assign rxData = rxData_q;

endmodule

// *** test/spcfg_host.sv ***
// host-side line model: drives the receive pins from one bit
module spcfg_host
  import spcfg_pkg::*;
(
  input wire logic bitVal,
  input wire logic use485,
  output logic rxLine,
  output logic rxPos
);
  timeunit 1ns;
  timeprecision 1ps;
  // pair in rs-485; in rs-232 the spare pin shows the inverse
  assign rxLine = use485 ? !bitVal : bitVal;
  assign rxPos = use485 ? bitVal : !bitVal;
endmodule

// *** test/spcfg_top_asserts.sv ***
// checker: capture and line relations of the config select
module spcfg_top_asserts
  import spcfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic selectPin,
  input wire logic [7:0] switchPins,
  input wire logic serialRxLine,
  input wire logic serialRxPos,
  input wire logic txData,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire spcfg_cfg_t portCfg,
  input wire logic cfgValid,
  input wire logic serialTxLine,
  input wire logic serialTxPos,
  input wire logic rxData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // divisor that the current rate code should give
  logic [15:0] expDiv;
  assign expDiv = portCfg.rateCode == RATE_38K4 ? DIV_38K4 :
    portCfg.rateCode == RATE_115K2 ? DIV_115K2 : DIV_9K6;
  // capture moment in rs-485 mode
  sequence capture_s;
    $rose(cfgValid) && portCfg.mode485;
  endsequence
  mode_select_a: assert property ($rose(cfgValid) |->
    portCfg.mode485 == !selectPin) else $error("mode not from select");
  sw_addr_a: assert property (capture_s |-> switchPins[5:0] == 6'h00 ||
    portCfg.nodeAddr == switchPins[5:0]) else $error("address bits");
  sw_rate_a: assert property (capture_s |-> switchPins[7:6] == 2'h0 ||
    portCfg.rateCode == switchPins[7:6]) else $error("rate bits");
  rs232_clear_a: assert property (cfgValid && !portCfg.mode485 |->
    portCfg.nodeAddr == 6'h00 && portCfg.rateCode == 2'h0) else $error("232");
  rate_div_a: assert property (cfgValid && portCfg.mode485 |->
    portCfg.baudDiv == expDiv) else $error("divisor mismatch");
  cfg_hold_a: assert property (cfgValid && $past(cfgValid) |->
    $stable(portCfg.mode485) && cfgValid) else $error("mode changed");
  tx_485_a: assert property (cfgValid && portCfg.mode485 |=>
    serialTxPos == $past(txData) && serialTxLine == !$past(txData))
    else $error("rs-485 transmit");
  tx_232_a: assert property (cfgValid && !portCfg.mode485 |=>
    serialTxLine == $past(txData) && !serialTxPos) else $error("rs-232 tx");
  rx_485_a: assert property (cfgValid && $past(cfgValid, 3) &&
    portCfg.mode485 |-> rxData == $past(serialRxPos, 3)) else $error("rx");
endmodule
bind spcfg_top spcfg_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .mclk, .rstn, .selectPin, .switchPins, .serialRxLine, .serialRxPos,
  .txData, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .portCfg, .cfgValid, .serialTxLine, .serialTxPos,
  .rxData
);

// *** test/tb_serial_port_config_select.sv ***
// bench: capture, fallback, line and register checks of the config select
module tb_serial_port_config_select
  import spcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic sel; logic [7:0] sw; logic [5:0] nvA;
    logic [1:0] nvR; spcfg_cfg_t exp;} spcfg_row_t;
  logic mclk = 0, rstn = 0, selectPin = 1, txData = 1, psel = 0;
  logic penable = 0, pwrite = 0, bitVal = 1, err;
  logic [7:0] switchPins = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, cfgValid, serialTxLine, serialTxPos, rxData;
  logic serialRxLine, serialRxPos;
  spcfg_cfg_t portCfg;
  int failures = 0, n_checks = 0, cyc = 0;
  // switch settings, stored values and the configuration they give
  spcfg_row_t rows[7] = '{
    '{1'b1, 8'hff, 6'h2a, 2'h3, '{1'b0, 6'h00, 2'h0, RS232_DIV_RST}},
    '{1'b1, 8'h00, 6'h2a, 2'h3, '{1'b0, 6'h00, 2'h0, RS232_DIV_RST}},
    '{1'b0, 8'h01, 6'h2a, 2'h2, '{1'b1, 6'h01, 2'h2, DIV_38K4}},
    '{1'b0, 8'h60, 6'h2a, 2'h3, '{1'b1, 6'h20, 2'h1, DIV_9K6}},
    '{1'b0, 8'h80, 6'h2a, 2'h1, '{1'b1, 6'h2a, 2'h2, DIV_38K4}},
    '{1'b0, 8'hc0, 6'h3f, 2'h0, '{1'b1, 6'h3f, 2'h3, DIV_115K2}},
    '{1'b0, 8'h00, 6'h15, 2'h0, '{1'b1, 6'h15, 2'h0, DIV_9K6}}};
  spcfg_top #(.SETTLE_CYCLES(4)) dut (.mclk, .rstn, .selectPin, .switchPins,
    .serialRxLine, .serialRxPos, .txData, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .portCfg, .cfgValid,
    .serialTxLine, .serialTxPos, .rxData);
  spcfg_host host (.bitVal, .use485(!selectPin), .rxLine(serialRxLine),
    .rxPos(serialRxPos));
  // clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset with given pins, then wait for the capture
  task automatic boot(input logic s, input logic [7:0] sw);
    rstn <= 1'b0;
    selectPin <= s;
    switchPins <= sw;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk("cfgValid early", 32'(cfgValid), 32'h0);
    do @(posedge mclk); while (cfgValid !== 1'b1);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // table rows, then registers, unmapped access and pin hold
  initial begin
    repeat (2) @(posedge mclk);
    foreach (rows[i]) begin
      boot(rows[i].sel, rows[i].sw);
      apb(1'b1, OFS_NV_ADDR, 32'(rows[i].nvA));
      apb(1'b1, OFS_NV_RATE, 32'(rows[i].nvR));
      repeat (2) @(posedge mclk);
      chk("cfg", 32'(portCfg), 32'(rows[i].exp));
      for (int b = 0; b < 2; b++) begin
        txData <= b[0];
        bitVal <= b[0];
        repeat (5) @(posedge mclk);
        chk("txLine", 32'(serialTxLine), 32'(b[0] ^ !rows[i].sel));
        chk("txPos", 32'(serialTxPos), 32'(b[0] & !rows[i].sel));
        chk("rxData", 32'(rxData), 32'(b[0]));
      end
    end
    boot(1'b0, 8'h05);
    apb(1'b0, OFS_NV_RATE, 32'h0);
    chk("nvRate reset", rd, 32'(NV_RATE_RST));
    apb(1'b0, OFS_RS232_DIV, 32'h0);
    chk("div reset", rd, 32'(RS232_DIV_RST));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0000050b);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("unmapped err", 32'(err), 32'h1);
    switchPins <= 8'hc2;
    selectPin <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("held", 32'(portCfg), 32'({1'b1, 6'h05, 2'h1, DIV_9K6}));
    // rs-232 divisor: low byte lane only, seen through the effective view
    boot(1'b1, 8'hff);
    pstrb <= 4'h1;
    apb(1'b1, OFS_RS232_DIV, 32'h0000_1234);
    pstrb <= 4'hf;
    apb(1'b0, OFS_EFFECT, 32'h0);
    chk("effect", rd, 32'h0834_0000);
    conclude();
  end
endmodule
